// >>> hw/pdr_ctrl.sv
// Notes on behaviour
// - Multiplier low byte locked while PLL on
// - Combined multiplier zero acts as one
// - Multiplier low resets to sixty-four
// - Range register locked while PLL on
// - Range zero disables PLL, clears select
// - No VCO selection with range zero
// - Range register resets to sixty-four
// - Auto mode: lock change raises interrupt
// - Flag sets regardless of interrupt enable
// - Manual mode: no interrupt, flag reads zero
// - VCO selectable while unlocked; software checks
// - Wait mode leaves clock generator unchanged
// - Stop without oscillator: oscillator, PLL, select, base clock and interrupt outputs low
// - Stop with oscillator: only PLL off
// - Protected break: register access keeps flag
// - Flag cleared in break stays cleared
// - Control register read clears flag
// - Base clock is selected source halved
`timescale 1ns/100ps
`include "pdr_map.svh"

module pdr_ctrl #(
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] mult_high,
  input wire logic lock_raw,
  input wire logic crystal_clock,
  input wire logic vco_clock,
  input wire logic stop_mode,
  input wire logic break_active,
  output pdr_pkg::pdr_clk_cfg_t clk_cfg,
  output logic base_clock_out,
  output logic clockgen_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  pdr_pkg::pdr_state_t state_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_en_q;
  logic flag_q;
  logic flag_d;
  logic pll_on_q;
  logic bcs_q;
  logic [1:0] vpr_q;
  logic auto_q;
  logic [7:0] mult_q;
  logic [7:0] vrs_q;
  logic osc_run_q;
  logic break_clear_enable_q;
  logic lock_s;
  logic lock_prev_q;
  logic xclk_s;
  logic vclk_s;
  logic src_prev_q;
  logic base_clk_q;
  logic irq_q;
  pdr_pkg::pdr_clk_cfg_t cfg_q;
  pdr_pkg::pdr_sel_t sel;
  logic acc;
  logic wr;
  logic rd;
  logic vrs_nz;
  logic lock_vis;
  logic flag_vis;
  logic flag_set;
  logic flag_clr;
  logic full_stop;
  logic src_now;
  logic [11:0] mult_all;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by read mux and write paths

  function automatic pdr_pkg::pdr_sel_t decode(input logic [AW-1:0] a);
    if (a == AW'(`PDR_OFS_CTRL)) begin
      decode = pdr_pkg::PDR_SEL_CTRL;
    end else if (a == AW'(`PDR_OFS_BW)) begin
      decode = pdr_pkg::PDR_SEL_BW;
    end else if (a == AW'(`PDR_OFS_MULT)) begin
      decode = pdr_pkg::PDR_SEL_MULT;
    end else if (a == AW'(`PDR_OFS_VRS)) begin
      decode = pdr_pkg::PDR_SEL_VRS;
    end else if (a == AW'(`PDR_OFS_MODE)) begin
      decode = pdr_pkg::PDR_SEL_MODE;
    end else begin
      decode = pdr_pkg::PDR_SEL_NONE;
    end
  endfunction

  assign sel = decode(paddr);
  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite && (sel != pdr_pkg::PDR_SEL_NONE);
  assign rd = acc && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for lock and the two source clocks

  pdr_sync #(
    .W(3)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .din({lock_raw, crystal_clock, vco_clock}),
    .dout({lock_s, xclk_s, vclk_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Derived conditions

  assign vrs_nz = (vrs_q != 8'h00);
  assign lock_vis = auto_q && lock_s;
  assign flag_vis = auto_q && flag_q;
  assign full_stop = stop_mode && !osc_run_q;
  assign mult_all = {mult_high, mult_q};

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: setup edge captures read data, access cycle answers

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= pdr_pkg::PDR_ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      case (state_q)
        pdr_pkg::PDR_ST_IDLE: begin
          if (psel && !penable) begin
            state_q <= pdr_pkg::PDR_ST_ANSWER;
            pready_q <= 1'b1;
            pslverr_q <= (sel == pdr_pkg::PDR_SEL_NONE);
            prdata_q <= 32'h0000_0000;
            if (!pwrite) begin
              if (sel == pdr_pkg::PDR_SEL_CTRL) begin
                prdata_q[`PDR_CTRL_IRQ_EN] <= irq_en_q;
                prdata_q[`PDR_CTRL_FLAG] <= flag_vis;
                prdata_q[`PDR_CTRL_PLL_ON] <= pll_on_q;
                prdata_q[`PDR_CTRL_BCS] <= bcs_q;
                prdata_q[`PDR_CTRL_VPR_HI:`PDR_CTRL_VPR_LO] <= vpr_q;
              end else if (sel == pdr_pkg::PDR_SEL_BW) begin
                prdata_q[`PDR_BW_AUTO] <= auto_q;
                prdata_q[`PDR_BW_LOCK] <= lock_vis;
              end else if (sel == pdr_pkg::PDR_SEL_MULT) begin
                prdata_q[7:0] <= mult_q;
              end else if (sel == pdr_pkg::PDR_SEL_VRS) begin
                prdata_q[7:0] <= vrs_q;
              end else if (sel == pdr_pkg::PDR_SEL_MODE) begin
                prdata_q[`PDR_MODE_OSC_RUN] <= osc_run_q;
                prdata_q[`PDR_MODE_BREAK_CLEAR_ENABLE] <= break_clear_enable_q;
              end
            end
          end
        end
        pdr_pkg::PDR_ST_ANSWER: begin
          state_q <= pdr_pkg::PDR_ST_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default: begin
          state_q <= pdr_pkg::PDR_ST_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable and bandwidth mode

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_en_q <= 1'b0;
      auto_q <= 1'b0;
    end else if (ce) begin
      if (wr && sel == pdr_pkg::PDR_SEL_BW) begin
        auto_q <= pwdata[`PDR_BW_AUTO];
      end
      // Enable is forced clear and read-only in manual mode
      if (!auto_q) begin
        irq_en_q <= 1'b0;
      end else if (wr && sel == pdr_pkg::PDR_SEL_CTRL) begin
        irq_en_q <= pwdata[`PDR_CTRL_IRQ_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock-change flag

  assign flag_set = auto_q && (lock_s != lock_prev_q);
  assign flag_clr = rd && (sel == pdr_pkg::PDR_SEL_CTRL) &&
                    prdata_q[`PDR_CTRL_FLAG] &&
                    !(break_active && !break_clear_enable_q);

  always_comb begin
    flag_d = flag_q;
    if (flag_clr) begin
      flag_d = 1'b0;
    end
    if (flag_set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end else if (ce) begin
      flag_q <= flag_d;
      lock_prev_q <= lock_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL on and base clock select with mutual protection

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pll_on_q <= `PDR_RST_PLL_ON;
      bcs_q <= 1'b0;
    end else if (ce) begin
      if (wr && sel == pdr_pkg::PDR_SEL_CTRL) begin
        // PLL cannot be switched off while it drives the base clock
        pll_on_q <= bcs_q | pwdata[`PDR_CTRL_PLL_ON];
        bcs_q <= pwdata[`PDR_CTRL_BCS] & pll_on_q & vrs_nz;
      end else if (!pll_on_q || !vrs_nz) begin
        bcs_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protected programming registers

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mult_q <= `PDR_RST_MULT;
      vrs_q <= `PDR_RST_VRS;
      vpr_q <= `PDR_RST_VPR;
    end else if (ce && wr && !pll_on_q) begin
      if (sel == pdr_pkg::PDR_SEL_MULT) begin
        mult_q <= pwdata[7:0];
      end else if (sel == pdr_pkg::PDR_SEL_VRS) begin
        vrs_q <= pwdata[7:0];
      end else if (sel == pdr_pkg::PDR_SEL_CTRL) begin
        vpr_q <= pwdata[`PDR_CTRL_VPR_HI:`PDR_CTRL_VPR_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode register: stop behaviour and break clearing

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      osc_run_q <= 1'b0;
      break_clear_enable_q <= 1'b0;
    end else if (ce && wr && sel == pdr_pkg::PDR_SEL_MODE) begin
      osc_run_q <= pwdata[`PDR_MODE_OSC_RUN];
      break_clear_enable_q <= pwdata[`PDR_MODE_BREAK_CLEAR_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings driven to the loop and oscillator

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q <= '0;
    end else if (ce) begin
      cfg_q.osc_en <= !full_stop;
      cfg_q.pll_en <= pll_on_q && vrs_nz && !stop_mode;
      cfg_q.base_sel <= bcs_q && !full_stop;
      cfg_q.vpr <= vpr_q;
      cfg_q.vrs <= vrs_q;
      cfg_q.mult_eff <= (mult_all == 12'h000) ? `PDR_MULT_MIN : mult_all;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Base clock divider and interrupt output

  assign src_now = bcs_q ? vclk_s : xclk_s;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      src_prev_q <= 1'b0;
      base_clk_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      src_prev_q <= src_now;
      if (full_stop) begin
        base_clk_q <= 1'b0;
        irq_q <= 1'b0;
      end else begin
        if (src_now && !src_prev_q) begin
          base_clk_q <= !base_clk_q;
        end
        irq_q <= flag_d && irq_en_q && auto_q;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign clk_cfg = cfg_q;
  assign base_clock_out = base_clk_q;
  assign clockgen_irq_out = irq_q;

endmodule

// >>> hw/pdr_map.svh
`ifndef PDR_MAP_SVH
`define PDR_MAP_SVH

// Register byte offsets
`define PDR_OFS_CTRL 8'h00
`define PDR_OFS_BW 8'h04
`define PDR_OFS_MULT 8'h08
`define PDR_OFS_VRS 8'h0C
`define PDR_OFS_MODE 8'h10

// Control register fields
`define PDR_CTRL_IRQ_EN 7
`define PDR_CTRL_FLAG 6
`define PDR_CTRL_PLL_ON 5
`define PDR_CTRL_BCS 4
`define PDR_CTRL_VPR_HI 1
`define PDR_CTRL_VPR_LO 0

// Bandwidth register fields
`define PDR_BW_AUTO 7
`define PDR_BW_LOCK 6

// Mode register fields
`define PDR_MODE_OSC_RUN 0
`define PDR_MODE_BREAK_CLEAR_ENABLE 1

// Reset values
`define PDR_RST_MULT 8'h40
`define PDR_RST_VRS 8'h40
`define PDR_RST_VPR 2'h0
`define PDR_RST_PLL_ON 1'b1

// Multiplier value used in place of zero
`define PDR_MULT_MIN 12'h001

`endif

// >>> hw/pdr_pkg.sv
package pdr_pkg;

  typedef enum logic [2:0] {
    PDR_SEL_CTRL = 3'h0,
    PDR_SEL_BW = 3'h1,
    PDR_SEL_MULT = 3'h2,
    PDR_SEL_VRS = 3'h3,
    PDR_SEL_MODE = 3'h4,
    PDR_SEL_NONE = 3'h7
  } pdr_sel_t;

  // Bus slave phase; Gray along idle -> answer
  typedef enum logic [1:0] {
    PDR_ST_IDLE = 2'b00,
    PDR_ST_ANSWER = 2'b01
  } pdr_state_t;

  // Settings handed to the analog loop and the clock mux
  typedef struct packed {
    logic osc_en;
    logic pll_en;
    logic base_sel;
    logic [1:0] vpr;
    logic [7:0] vrs;
    logic [11:0] mult_eff;
  } pdr_clk_cfg_t;

endpackage

// >>> hw/pdr_sync.sv
`timescale 1ns/100ps

module pdr_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] dout_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once the second and third stage agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          dout_q[i] <= 1'b0;
        end else if (ce && (s2_q[i] == s3_q[i])) begin
          dout_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

  assign dout = dout_q;

endmodule

// >>> sim/pdr_ctrl_sva.sv
`timescale 1ns/100ps
module pdr_ctrl_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_mode,
  input wire pdr_pkg::pdr_clk_cfg_t clk_cfg,
  input wire logic base_clock_out,
  input wire logic clockgen_irq_out
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready held too long");
  property p_err; pslverr && !pwrite |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  property p_mult; $past(rst_n) |-> clk_cfg.mult_eff != 12'h000;
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier zero");
  property p_vrs; clk_cfg.pll_en |-> clk_cfg.vrs != 8'h00; endproperty
  a_vrs: assert property (p_vrs) else $error("pll on, range zero");
  property p_bsel; clk_cfg.base_sel |-> clk_cfg.vrs != 8'h00; endproperty
  a_bsel: assert property (p_bsel) else $error("vco sel, range 0");
  property p_full; $past(rst_n) && !clk_cfg.osc_en |->
    !base_clock_out && !clk_cfg.pll_en && !clk_cfg.base_sel; endproperty
  a_full: assert property (p_full) else $error("stop outputs high");
  property p_irq; clockgen_irq_out |-> clk_cfg.osc_en; endproperty
  a_irq: assert property (p_irq) else $error("irq in full stop");
  property p_stp; stop_mode |=> !clk_cfg.pll_en; endproperty
  a_stp: assert property (p_stp) else $error("pll on in stop");
  c_irq: cover property (clockgen_irq_out);
  c_vco: cover property (clk_cfg.base_sel);
  c_err: cover property (pslverr);
endmodule
bind pdr_ctrl pdr_ctrl_sva pdr_ctrl_sva_inst (.mclk(mclk), .rst_n(rst_n),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_mode(stop_mode), .clk_cfg(clk_cfg), .base_clock_out(base_clock_out),
  .clockgen_irq_out(clockgen_irq_out));

// >>> sim/pdr_ctrl_bench.sv
`timescale 1ns/100ps
`include "pdr_map.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module pdr_ctrl_bench;
  localparam logic [7:0] O_C = `PDR_OFS_CTRL;
  localparam logic [7:0] O_B = `PDR_OFS_BW;
  localparam logic [7:0] O_M = `PDR_OFS_MULT;
  localparam logic [7:0] O_V = `PDR_OFS_VRS;
  localparam logic [7:0] O_D = `PDR_OFS_MODE;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic ce;
  logic lock_raw, crystal_clock, vco_clock, stop_mode, break_active;
  logic base_clock_out, clockgen_irq_out;
  logic [7:0] paddr, cnt;
  logic [31:0] pwdata, prdata;
  logic [3:0] mult_high;
  pdr_pkg::pdr_clk_cfg_t clk_cfg;
  int miscompares, n_tests;
  pdr_ctrl pdr_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mult_high(mult_high), .lock_raw(lock_raw),
    .crystal_clock(crystal_clock), .vco_clock(vco_clock),
    .stop_mode(stop_mode), .break_active(break_active), .clk_cfg(clk_cfg),
    .base_clock_out(base_clock_out), .clockgen_irq_out(clockgen_irq_out));
  ////////////////////////////////////////
  // Source clocks: crystal 16 cycles, vco 8 cycles
  always @(posedge mclk) begin
    cnt <= cnt + 8'h01;
    crystal_clock <= cnt[3];
    vco_clock <= cnt[2];
  end
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Waits for pready; the watchdog ends it only if no answer comes
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    `CHK(r, x)
  endtask
  task w3;
    repeat (3) @(negedge mclk);
  endtask
  task lk(input logic v);
    @(posedge mclk) lock_raw <= v;
    repeat (8) @(negedge mclk);
  endtask
  task automatic t_base(input int x);
    int n;
    logic p;
    n = 0;
    repeat (40) @(negedge mclk);
    p = base_clock_out;
    repeat (64) begin
      @(negedge mclk);
      if (base_clock_out === 1'b1 && p === 1'b0) n++;
      p = base_clock_out;
    end
    `CHK(n, x)
  endtask
  ////////////////////////////////////////
  task t_rst;
    rd(O_C, 32'h20); rd(O_B, 32'h0); rd(O_D, 32'h0);
    rd(O_M, 32'h40);
    rd(O_V, 32'h40);
    w3;
    `CHK(clk_cfg.mult_eff, 12'h340)
    t_base(2);
  endtask
  task t_prot;
    wr(O_M, 32'h12); rd(O_M, 32'h40);
    wr(O_V, 32'h12); rd(O_V, 32'h40);
    wr(O_C, 32'h03); rd(O_C, 32'h00);
    mult_high <= 4'h0;
    wr(O_M, 32'h00); wr(O_V, 32'h00);
    w3;
    `CHK(clk_cfg.mult_eff, 12'h001)
    wr(O_C, 32'h30); wr(O_C, 32'h30); rd(O_C, 32'h20);
    w3;
    `CHK(clk_cfg.pll_en, 1'b0)
    wr(O_C, 32'h00); wr(O_V, 32'h40); wr(O_M, 32'h20);
    wr(O_C, 32'h20); wr(O_C, 32'h30); rd(O_C, 32'h30);
    t_base(4);
  endtask
  task t_irq;
    wr(O_B, 32'h80); wr(O_C, 32'hB0);
    lk(1'b1);
    `CHK(clockgen_irq_out, 1'b1)
    rd(O_C, 32'hF0); rd(O_C, 32'hB0);
    wr(O_C, 32'h30);
    lk(1'b0);
    `CHK(clockgen_irq_out, 1'b0)
    @(posedge mclk) break_active <= 1'b1;
    rd(O_C, 32'h70); wr(O_C, 32'h30); rd(O_C, 32'h70);
    wr(O_D, 32'h02); rd(O_C, 32'h70); rd(O_C, 32'h30);
    @(posedge mclk) break_active <= 1'b0;
    rd(O_C, 32'h30);
    lk(1'b1);
    wr(O_B, 32'h00);
    rd(O_C, 32'h30); rd(O_B, 32'h00);
  endtask
  task t_stop;
    @(posedge mclk) stop_mode <= 1'b1;
    w3;
    `CHK(clk_cfg.osc_en, 1'b0)
    `CHK(base_clock_out, 1'b0)
    `CHK(clk_cfg.base_sel, 1'b0)
    wr(O_D, 32'h01);
    w3;
    `CHK(clk_cfg.osc_en, 1'b1)
    `CHK(clk_cfg.pll_en, 1'b0)
    @(posedge mclk) stop_mode <= 1'b0;
    rd(8'h14, 32'h0);
    `CHK(err, 1'b1)
  endtask
  // Clock enable low must freeze the running base clock divider
  task t_ce;
    logic b;
    @(posedge mclk) ce <= 1'b0;
    @(negedge mclk);
    b = base_clock_out;
    repeat (40) @(negedge mclk);
    `CHK(base_clock_out, b)
    @(posedge mclk) ce <= 1'b1;
  endtask
  task test_done;
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    test_done;
  end
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; mult_high = 4'h3; lock_raw = 1'b0; cnt = 8'h00;
    crystal_clock = 1'b0; vco_clock = 1'b0; stop_mode = 1'b0;
    break_active = 1'b0; err = 1'b0; miscompares = 0; n_tests = 0;
    ce = 1'b1;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_rst;
    t_prot;
    t_irq;
    t_stop;
    t_ce;
    test_done;
  end
endmodule
